// file: bench/pdar_checker.sv
`timescale 1ns/1ps
// ****
// Strobe timing checks
// ****
module pdar_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Watched pins
	input wire logic host_rw,
	input wire logic host_data_oe,
	input wire pdar_pkg::pdar_strobes_type ram_strobes
);
	import pdar_pkg::*;
	logic row_on; // Any row strobe active
	assign row_on = ~&{ram_strobes.bank_row_strobe_n, ram_strobes.fourth_bank_row_strobe_n};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Row and column strobes back at rest
	sequence s_rest;
		!row_on && ram_strobes.column_strobe_n && ram_strobes.column_phase_n;
	endsequence
	// Column phase four clocks after the row strobe
	sequence s_colph;
		ram_strobes.column_phase_n [*4] ##1 !ram_strobes.column_phase_n;
	endsequence
	// Column strobe three clocks after column phase
	sequence s_cas;
		ram_strobes.column_strobe_n [*3] ##1 !ram_strobes.column_strobe_n;
	endsequence
	property p_row_col;
		$rose(row_on) |-> s_colph;
	endproperty
	a_row_col: assert property (p_row_col) else $error("column phase late or early");
	property p_col_cas;
		$fell(ram_strobes.column_phase_n) |-> s_cas;
	endproperty
	a_col_cas: assert property (p_col_cas) else $error("column strobe mistimed");
	property p_cap_len;
		$rose(ram_strobes.data_capture) |->
			##11 ram_strobes.data_capture ##1 !ram_strobes.data_capture;
	endproperty
	a_cap_len: assert property (p_cap_len) else $error("capture width wrong");
	property p_release;
		$fell(ram_strobes.data_capture) |-> ##[1:3] s_rest;
	endproperty
	a_release: assert property (p_release) else $error("strobes not released");
	property p_we_cap;
		!ram_strobes.write_enable_n |-> ram_strobes.data_capture;
	endproperty
	a_we_cap: assert property (p_we_cap) else $error("write enable without capture");
	property p_ref_we;
		!(row_on && |{ram_strobes.bank_row_strobe_n, ram_strobes.fourth_bank_row_strobe_n})
			|-> ram_strobes.write_enable_n;
	endproperty
	a_ref_we: assert property (p_ref_we) else $error("write during refresh");
	property p_oe_rd;
		host_data_oe |-> $past(host_rw, 2) || $past(host_rw, 3);
	endproperty
	a_oe_rd: assert property (p_oe_rd) else $error("data driven on a write");
	property p_row_hold;
		$rose(row_on) |-> row_on [*8];
	endproperty
	a_row_hold: assert property (p_row_hold) else $error("row strobe dropped early");
endmodule

bind pdar_top pdar_checker u_checker (.mclk(mclk), .rst_n(rst_n), .host_rw(host_rw),
	.host_data_oe(host_data_oe), .ram_strobes(ram_strobes));

// file: bench/pdar_host_model.sv
`timescale 1ns/1ps
// ****
// Host bus: free running E and Q, address held
// ****
module pdar_host_model #(
	parameter int QUARTER = 15
) (
	// Clock
	input wire logic mclk,
	// Next request from the bench
	input wire logic [15:0] req_addr,
	input wire logic req_rw,
	input wire logic [7:0] req_data,
	// Host pins
	output logic [15:0] host_addr,
	output logic host_rw,
	output logic host_e,
	output logic host_q,
	output logic [7:0] host_data_in
);
	int phase = 0; // Position within one E period
	// Q leads E by a quarter period
	assign host_q = (phase < 2 * QUARTER);
	assign host_e = (phase >= QUARTER) && (phase < 3 * QUARTER);
	initial begin
		host_addr = 16'h0000;
		host_rw = 1'b1;
		host_data_in = 8'h00;
	end
	// Pins change only as E falls, so they stand from Q rise to E fall
	always @(posedge mclk) begin
		phase <= (phase + 1) % (4 * QUARTER);
		if (phase == 3 * QUARTER - 1) begin
			host_addr <= req_addr;
			host_rw <= req_rw;
			// A released bus does not keep the old value
			host_data_in <= req_rw ? ~host_data_in : req_data;
		end
	end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps
// ****
// Bench for the paged RAM controller
// ****
module tb_top;
	import pdar_pkg::*;
	logic mclk, rst_n, hsel, hwrite, hreadyout, host_rw, host_e, host_q;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, hresp;
	logic [2:0] hsize;
	logic [15:0] host_addr, req_addr;
	logic [7:0] host_data_in, host_data_out, ram_dq_in, ram_dq_out, req_data;
	logic host_data_oe, r0sw, r1sw, bank_half_bit, refresh_addr_select, req_rw;
	logic [6:0] ram_addr, r0;
	logic [3:0] rows_n; // Fourth bank first
	pdar_strobes_type ram_strobes;
	int err_count = 0;
	int num_checks = 0;
	assign rows_n = {ram_strobes.fourth_bank_row_strobe_n, ram_strobes.bank_row_strobe_n};
	pdar_host_model #(.QUARTER(15)) host (.mclk(mclk), .req_addr(req_addr),
		.req_rw(req_rw), .req_data(req_data), .host_addr(host_addr), .host_rw(host_rw),
		.host_e(host_e), .host_q(host_q), .host_data_in(host_data_in));
	pdar_top dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .host_addr(host_addr),
		.host_rw(host_rw), .host_e(host_e), .host_q(host_q), .host_data_in(host_data_in),
		.host_data_out(host_data_out), .host_data_oe(host_data_oe),
		.region0_rom_switch(r0sw), .region1_rom_switch(r1sw), .ram_dq_in(ram_dq_in),
		.ram_dq_out(ram_dq_out), .ram_addr(ram_addr), .bank_half_bit(bank_half_bit),
		.refresh_addr_select(refresh_addr_select), .ram_strobes(ram_strobes));
	// Free running 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Verdict and end of run
	task automatic wrap_up;
		if (err_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Wait conditions, sampled after the edge has settled
	function automatic bit hit(input int s);
		case (s)
			0: return !host_e;
			1: return host_e;
			2: return !ram_strobes.column_strobe_n && host_e;
			3: return ram_strobes.data_capture && host_e;
			4: return !ram_strobes.data_capture;
			default: return rows_n === 4'h0;
		endcase
	endfunction
	// Bounded wait; running out ends the run
	task automatic tick_until(input int s, input string nm);
		int i;
		for (i = 0; i < 400; i++) begin
			if (hit(s)) return;
			@(posedge mclk);
			#1;
		end
		chk(nm, 1, 0);
		wrap_up();
	endtask
	// Bounded wait for hready at a rising edge; running out ends the run
	task automatic wait_ready;
		int n;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (hreadyout === 1'b1) return;
		end
		chk("hready", 1, 0);
		wrap_up();
	endtask
	// One single AHB-Lite word transfer
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		chk("bus response", HRESP_OKAY, hresp);
	endtask
	// One host cycle with the strobes it must raise
	task automatic access(input logic [15:0] a, input logic rw, input logic [3:0] rows,
		input logic half);
		logic [7:0] d;
		d = a[7:0] ^ 8'h5a;
		@(posedge mclk);
		req_addr <= a;
		req_rw <= rw;
		req_data <= d;
		ram_dq_in <= d;
		// Let a host latch edge pass first, so a stale address never counts
		@(posedge mclk);
		#1;
		tick_until(1, "e high");
		tick_until(0, "e low");
		tick_until(1, "access phase");
		if (rows != 4'hf) begin
			tick_until(2, "column strobe");
			chk("column address", {half, a[12:7]}, ram_addr);
		end
		tick_until(3, "capture");
		chk("row strobes", rows, rows_n);
		chk("bank half", half, bank_half_bit);
		if (rows != 4'hf) begin
			chk("write enable", rw, ram_strobes.write_enable_n);
			chk("data drive", rw, host_data_oe);
			if (!rw) begin
				chk("ram write data", d, ram_dq_out);
			end else begin
				tick_until(4, "capture end");
				@(posedge mclk);
				ram_dq_in <= ~d;
				repeat (4) @(posedge mclk);
				chk("held read data", d, host_data_out);
			end
		end
	endtask
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		{r0sw, r1sw, ram_dq_in} = '0;
		{req_addr, req_rw, req_data} = {16'h0000, 1'b1, 8'h00};
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		ahb(0, CTRL_OFS, 0);
		chk("ctrl reset", CTRL_RESET, rd);
		ahb(1, 32'h0000_0040, 32'hffff_ffff);
		ahb(0, 32'h0000_0040, 0);
		chk("unmapped read", 0, rd);
		// Every page through the window, reads and writes alternating
		for (int p = 0; p < 8; p++) begin
			ahb(1, CTRL_OFS, 32'h0000_0018 | p);
			ahb(0, CTRL_OFS, 0);
			chk("page bits", 32'h0000_0018 | p, rd);
			access(16'h8000 | 16'(p * 16'h0481), p[0], ~(4'h1 << p[1:0]), p[2]);
		end
		// Overlays open, then region 0 closed, then an unrelated address
		access(16'hc123, 1'b0, ~FOURTH_BANK, 1'b1);
		access(16'ha321, 1'b1, ~FOURTH_BANK, 1'b0);
		@(posedge mclk);
		r0sw <= 1'b1;
		access(16'hc040, 1'b1, 4'hf, 1'b1);
		access(16'h1000, 1'b1, 4'hf, 1'b1);
		// Refresh row steps once per period and wraps
		tick_until(5, "refresh rows");
		chk("refresh select", 1, refresh_addr_select);
		chk("refresh no write", 1, ram_strobes.write_enable_n);
		r0 = ram_addr;
		ahb(0, STAT_OFS, 0);
		chk("status row", r0, rd[6:0]);
		repeat (130 * 60 - 3) @(posedge mclk);
		#1;
		tick_until(5, "later refresh");
		chk("row after wrap", 7'(r0 + 7'h02), ram_addr);
		wrap_up();
	end
endmodule

// file: logic/pdar_pkg.sv
package pdar_pkg;

	// ****************************************
	// Timing figures and derived clock counts
	// ****************************************
	localparam int CLK_PERIOD_NS = 5; // mclk period at 200 MHz
	localparam int ROW_TO_COL_NS = 20; // Row strobe to column phase switch
	localparam int COL_TO_CAS_NS = 15; // Column phase to column strobe
	localparam int CAP_HOLD_NS = 60; // Capture strobe width before self clear
	localparam int CYC_TAIL_NS = 10; // Capture end to cycle flip-flop clear
	localparam logic [3:0] ROW_TO_COL_CYC =
		4'((ROW_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] COL_TO_CAS_CYC =
		4'((COL_TO_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] CAP_HOLD_CYC =
		4'((CAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] CYC_TAIL_CYC =
		4'((CYC_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00; // Page bits and region enables
	localparam logic [7:0] STAT_OFS = 8'h04; // Live timing state
	localparam int CTRL_PAGE_LSB = 0; // Three page bits
	localparam int CTRL_R0EN_BIT = 3; // Region 0 response enable
	localparam int CTRL_R1EN_BIT = 4; // Region 1 response enable
	localparam logic [31:0] CTRL_RESET = 32'h0000_0018;
	localparam int STAT_ROW_LSB = 0; // Refresh row counter, seven bits
	localparam int STAT_CYC_BIT = 8; // Cycle flip-flop
	localparam int STAT_CAP_BIT = 9; // Capture flip-flop
	localparam int STAT_REF_BIT = 10; // Current cycle is a refresh
	localparam int STAT_E_BIT = 11; // Synchronised E
	localparam int STAT_Q_BIT = 12; // Synchronised Q

	// ****************************************
	// Address decode and bus codes
	// ****************************************
	localparam logic [2:0] WIN_TOP = 3'h4; // 8000 to 9FFF
	localparam logic [2:0] REGION1_TOP = 3'h5; // A000 to BFFF
	localparam logic [2:0] REGION0_TOP = 3'h6; // C000 to DFFF
	localparam logic [3:0] FOURTH_BANK = 4'h8;
	localparam logic [3:0] ALL_BANKS = 4'hf;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		T_IDLE, T_ROW, T_COLPH, T_CAS, T_CAP, T_END
	} pdar_tstate_type;

	// Pins from the host bus and the RAM array, all asynchronous
	typedef struct packed {
		logic [15:0] addr;
		logic rw;
		logic e;
		logic q;
		logic [7:0] data;
		logic [7:0] ram_dq;
		logic region0_rom_switch;
		logic region1_rom_switch;
	} pdar_pins_type;

	// Strobes towards the RAM array
	typedef struct packed {
		logic [2:0] bank_row_strobe_n;
		logic fourth_bank_row_strobe_n;
		logic column_phase_n;
		logic column_strobe_n;
		logic write_enable_n;
		logic data_capture;
	} pdar_strobes_type;

endpackage

// file: logic/pdar_refresh_ctr.sv
`timescale 1ns/1ps
module pdar_refresh_ctr (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// One pulse per high phase of Q
	input wire logic inc,
	// Current refresh row
	output logic [6:0] row
);

	logic [6:0] cnt_reg; // Row counter
	logic [6:0] cnt_next;

	// Natural wrap from the top row to zero, no host help needed
	always_comb begin
		cnt_next = cnt_reg;
		if (inc) begin
			cnt_next = cnt_reg + 7'h01;
		end
	end

	// Counter register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 7'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign row = cnt_reg;

endmodule

// file: logic/pdar_sync.sv
`timescale 1ns/1ps
module pdar_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// First stage, read only by the second stage
	logic [W-1:0] meta_reg;

	// ****************************************
	// Two flip-flops per bit
	// ****************************************
	for (genvar i = 0; i < W; i++) begin : g_bit
		// Metastability settles in the first stage
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				meta_reg[i] <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta_reg[i] <= async_in[i];
				sync_out[i] <= meta_reg[i];
			end
		end
	end

endmodule

// file: logic/pdar_top.sv
// Contract
// - Window select for 8000 to 9FFF
// - Low page bits pick one bank
// - High page bit picks bank half
// - Enabled overlay regions use fourth bank
// - Overlay half bit is inverted A13
// - Drive host data only on reads
// - Address lines: row, column, refresh
// - Holding latch follows strobe, then holds
// - Access while E high, refresh low
// - XOR fall sets cycle, row strobe
// - Delay, column phase, delay, column strobe
// - XOR rise sets capture strobe
// - Write enable with capture on writes
// - Capture self clears, then cycle clears
// - Seven-bit row counter, once per Q high
// - Q low selects refresh address
// - Refresh strobes all four banks
// - Whole RAM refreshed per 128 Q periods
// - Refresh uses access strobe sequence
// - Closed switch ROM, open switch RAM
`timescale 1ns/1ps
module pdar_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	// Host bus pins
	input wire logic [15:0] host_addr,
	input wire logic host_rw,
	input wire logic host_e,
	input wire logic host_q,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	// Region switches, high when closed
	input wire logic region0_rom_switch,
	input wire logic region1_rom_switch,
	// RAM array
	input wire logic [7:0] ram_dq_in,
	output logic [7:0] ram_dq_out,
	output logic [6:0] ram_addr,
	output logic bank_half_bit,
	output logic refresh_addr_select,
	output pdar_pkg::pdar_strobes_type ram_strobes
);
	import pdar_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		pdar_tstate_type tst; // Strobe sequencer
		logic [3:0] tmr; // Delay counter
		logic refresh; // Cycle was started with E low
		logic [3:0] banks; // Row strobes for this cycle
		logic wr; // Cycle is a host write
		logic [7:0] hold; // Read data holding latch
		logic [2:0] page; // Page bits
		logic r0en; // Region 0 response enable
		logic r1en; // Region 1 response enable
		logic xor_d; // Previous synchronised E xor Q
		logic q_d; // Previous synchronised Q
		logic ph_wr; // Pending register write
		logic [7:0] ph_addr; // Address of pending write
		logic [31:0] rdata; // Read data for the data phase
	} pdar_state_type;

	pdar_state_type s_reg; // Registered state
	pdar_state_type s_next; // Next state

	pdar_pins_type pins_raw; // Pins as they arrive
	pdar_pins_type pins; // Pins after two flip-flops
	logic [6:0] ref_row; // Refresh counter value
	logic x; // E xor Q
	logic x_fall; // Start of a strobe sequence
	logic x_rise; // Capture point
	logic q_rise; // Counter advance point
	logic win_sel; // Paged window addressed
	logic ov0_sel; // Region 0 overlay addressed
	logic ov1_sel; // Region 1 overlay addressed
	logic acc_sel; // Any RAM access addressed
	logic half; // Bank half for the live address
	logic cyc; // Cycle flip-flop
	logic cap; // Capture flip-flop
	logic col_ph; // Column phase active
	logic col_st; // Column strobe active
	logic ahb_take; // Address phase accepted

	// ****************************************
	// Decode functions
	// ****************************************
	// One-hot bank pick from two page bits
	function automatic logic [3:0] bank_onehot(input logic [1:0] pg);
		bank_onehot = 4'h1 << pg;
	endfunction

	// Region hit on the top three address bits
	function automatic logic region_hit(input logic [15:0] a, input logic [2:0] top);
		region_hit = (a[15:13] == top);
	endfunction

	// Register read word for an offset
	function automatic logic [31:0] read_word(input logic [7:0] ofs,
		input pdar_state_type st, input logic [6:0] rr, input pdar_pins_type p);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (ofs == CTRL_OFS) begin
			w[CTRL_PAGE_LSB +: 3] = st.page;
			w[CTRL_R0EN_BIT] = st.r0en;
			w[CTRL_R1EN_BIT] = st.r1en;
		end else if (ofs == STAT_OFS) begin
			w[STAT_ROW_LSB +: 7] = rr;
			w[STAT_CYC_BIT] = (st.tst != T_IDLE);
			w[STAT_CAP_BIT] = (st.tst == T_CAP);
			w[STAT_REF_BIT] = st.refresh;
			w[STAT_E_BIT] = p.e;
			w[STAT_Q_BIT] = p.q;
		end
		read_word = w;
	endfunction

	// ****************************************
	// Pin synchronisation
	// ****************************************
	// Gather every outside level into one vector
	always_comb begin
		pins_raw.addr = host_addr;
		pins_raw.rw = host_rw;
		pins_raw.e = host_e;
		pins_raw.q = host_q;
		pins_raw.data = host_data_in;
		pins_raw.ram_dq = ram_dq_in;
		pins_raw.region0_rom_switch = region0_rom_switch;
		pins_raw.region1_rom_switch = region1_rom_switch;
	end

	// Adds two cycles of latency to every pin, well inside the E phases
	pdar_sync #(.W($bits(pdar_pins_type))) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(pins_raw),
		.sync_out(pins)
	);

	// Refresh row counter, advanced on each rise of Q
	pdar_refresh_ctr u_ctr (
		.mclk(mclk),
		.rst_n(rst_n),
		.inc(q_rise),
		.row(ref_row)
	);

	// ****************************************
	// Edges and address decode
	// ****************************************
	// Host clocks arrive as quadrature pair
	always_comb begin
		x = pins.e ^ pins.q;
		x_fall = s_reg.xor_d & ~x;
		x_rise = ~s_reg.xor_d & x;
		q_rise = ~s_reg.q_d & pins.q;
	end

	// Window and overlay selects; an open switch means RAM
	always_comb begin
		win_sel = region_hit(pins.addr, WIN_TOP);
		ov0_sel = region_hit(pins.addr, REGION0_TOP) & s_reg.r0en
			& ~pins.region0_rom_switch;
		ov1_sel = region_hit(pins.addr, REGION1_TOP) & s_reg.r1en
			& ~pins.region1_rom_switch;
		acc_sel = win_sel | ov0_sel | ov1_sel;
		if (win_sel) begin
			half = s_reg.page[2];
		end else begin
			half = ~pins.addr[13];
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		s_next.xor_d = x;
		s_next.q_d = pins.q;
		ahb_take = hsel & htrans[1] & hready;

		// Strobe sequencer, same for access and refresh
		case (s_reg.tst)
			T_IDLE: begin
				if (x_fall) begin
					// Cycle flip-flop set, row strobe on
					s_next.tst = T_ROW;
					s_next.tmr = ROW_TO_COL_CYC;
					s_next.refresh = ~pins.e;
					s_next.wr = pins.e & acc_sel & ~pins.rw;
					if (!pins.e) begin
						s_next.banks = ALL_BANKS;
					end else if (win_sel) begin
						s_next.banks = bank_onehot(s_reg.page[1:0]);
					end else if (ov0_sel | ov1_sel) begin
						s_next.banks = FOURTH_BANK;
					end else begin
						s_next.banks = 4'h0; // Not ours, no row strobe
					end
				end
			end
			T_ROW: begin
				// Row hold time before switching to columns
				if (x_rise) begin
					s_next.tst = T_CAP;
					s_next.tmr = CAP_HOLD_CYC;
				end else if (s_reg.tmr == 4'h1) begin
					s_next.tst = T_COLPH;
					s_next.tmr = COL_TO_CAS_CYC;
				end else begin
					s_next.tmr = s_reg.tmr - 4'h1;
				end
			end
			T_COLPH: begin
				// Column address settles before the column strobe
				if (x_rise) begin
					s_next.tst = T_CAP;
					s_next.tmr = CAP_HOLD_CYC;
				end else if (s_reg.tmr == 4'h1) begin
					s_next.tst = T_CAS;
				end else begin
					s_next.tmr = s_reg.tmr - 4'h1;
				end
			end
			T_CAS: begin
				// Wait for the capture point
				if (x_rise) begin
					s_next.tst = T_CAP;
					s_next.tmr = CAP_HOLD_CYC;
				end
			end
			T_CAP: begin
				// Capture flip-flop clears itself after its delay
				if (s_reg.tmr == 4'h1) begin
					s_next.tst = T_END;
					s_next.tmr = CYC_TAIL_CYC;
				end else begin
					s_next.tmr = s_reg.tmr - 4'h1;
				end
			end
			T_END: begin
				// Cycle flip-flop falls, all strobes drop
				if (s_reg.tmr == 4'h1) begin
					s_next.tst = T_IDLE;
					s_next.banks = 4'h0;
					s_next.wr = 1'b0;
				end else begin
					s_next.tmr = s_reg.tmr - 4'h1;
				end
			end
			default: begin
				s_next.tst = T_IDLE;
			end
		endcase

		// Latch is transparent while capturing, holds afterwards
		if (s_reg.tst == T_CAP) begin
			s_next.hold = pins.ram_dq;
		end

		// Register write in the data phase
		if (s_reg.ph_wr && s_reg.ph_addr == CTRL_OFS) begin
			s_next.page = hwdata[CTRL_PAGE_LSB +: 3];
			s_next.r0en = hwdata[CTRL_R0EN_BIT];
			s_next.r1en = hwdata[CTRL_R1EN_BIT];
		end

		// Address phase: note writes, prepare read data
		s_next.ph_wr = ahb_take & hwrite;
		if (ahb_take) begin
			s_next.ph_addr = haddr[7:0];
		end
		if (ahb_take && !hwrite) begin
			s_next.rdata = read_word(haddr[7:0], s_reg, ref_row, pins);
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg.tst <= T_IDLE;
			s_reg.tmr <= 4'h0;
			s_reg.refresh <= 1'b0;
			s_reg.banks <= 4'h0;
			s_reg.wr <= 1'b0;
			s_reg.hold <= 8'h00;
			s_reg.page <= CTRL_RESET[CTRL_PAGE_LSB +: 3];
			s_reg.r0en <= CTRL_RESET[CTRL_R0EN_BIT];
			s_reg.r1en <= CTRL_RESET[CTRL_R1EN_BIT];
			s_reg.xor_d <= 1'b0;
			s_reg.q_d <= 1'b0;
			s_reg.ph_wr <= 1'b0;
			s_reg.ph_addr <= 8'h00;
			s_reg.rdata <= 32'h0000_0000;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Strobe levels from the sequencer state
	always_comb begin
		cyc = (s_reg.tst != T_IDLE);
		cap = (s_reg.tst == T_CAP);
		col_ph = (s_reg.tst == T_COLPH) | (s_reg.tst == T_CAS) | cap
			| (s_reg.tst == T_END);
		col_st = (s_reg.tst == T_CAS) | cap | (s_reg.tst == T_END);
	end

	// RAM strobes, all active low except the capture
	always_comb begin
		ram_strobes.bank_row_strobe_n = ~(s_reg.banks[2:0] & {3{cyc}});
		ram_strobes.fourth_bank_row_strobe_n = ~(s_reg.banks[3] & cyc);
		ram_strobes.column_phase_n = ~col_ph;
		ram_strobes.column_strobe_n = ~col_st;
		ram_strobes.write_enable_n = ~(cap & s_reg.wr);
		ram_strobes.data_capture = cap;
	end

	// Address multiplexer; Q low overrides with the refresh row
	always_comb begin
		refresh_addr_select = ~pins.q;
		bank_half_bit = half;
		if (refresh_addr_select) begin
			ram_addr = ref_row;
		end else if (col_ph) begin
			ram_addr = {half, pins.addr[12:7]};
		end else begin
			ram_addr = pins.addr[6:0];
		end
	end

	// Host data drive only for reads of our RAM while E is high
	always_comb begin
		host_data_oe = pins.e & acc_sel & pins.rw;
		host_data_out = s_reg.hold;
		ram_dq_out = pins.data;
	end

	// Zero wait state slave, always OKAY
	always_comb begin
		hreadyout = 1'b1;
		hresp = HRESP_OKAY;
		hrdata = s_reg.rdata;
	end

endmodule
